// ### core/pfh_host_port.sv
// packet fifo host port: wishbone registers, receive and transmit byte queues
// Function
// R1: mac configuration and phy management reachable through host registers
// R2: each receive port read returns the next byte of the frame in order
// R3: host reads only while queue not empty and no end of frame seen
// R4: last byte carries end of frame; empty reported when no bytes remain
// R5: host clears packet ready; receive buffer then free for next frame
// R6: host waits for transmit done or empty transmit queue before loading
// R7: host writes bytes with end-of-frame bit zero except the last
// R8: host sets end-of-frame bit to one before writing the final byte
// R9: each transmit port write pushes byte plus marker into queue at once
// R10: host sets packet ready; device then starts transmitting queued frame
// R11: transmit port writes while queue full are ignored
`timescale 1ns/1ps
module pfh_host_port #(
    parameter int DEPTH = 2048,
    parameter int AW = $clog2(DEPTH)
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // interrupt
    output logic irq_o,
    // mac configuration and phy management
    output logic [31:0] mac_cfg_o,
    output logic mgmt_start_o,
    output logic mgmt_write_o,
    output logic [30:0] mgmt_cmd_o,
    input wire logic mgmt_busy_i,
    input wire logic [15:0] mgmt_rdata_i,
    // receive side from mac
    input wire logic rx_wr_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_eof_i,
    output logic rx_ready_o,
    // transmit side to mac
    output logic tx_frame_o,
    output logic tx_avail_o,
    input wire logic tx_rd_i,
    output logic [7:0] tx_data_o,
    output logic tx_eof_o,
    input wire logic tx_done_i
);
    // ==================================================================
    // bus decode
    logic req, ack_q, acc, wr_acc, rd_acc;
    assign req = wb_cyc_i && wb_stb_i;
    assign acc = ce_i && req && !ack_q; // the single cycle an access acts
    assign wr_acc = acc && wb_we_i && wb_sel_i[0];
    assign rd_acc = acc && !wb_we_i;
    assign wb_ack_o = ack_q;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a[7:2] == off[7:2];
    endfunction : hit

    function automatic logic [AW:0] inc(input logic [AW:0] v);
        return v + {{AW{1'b0}}, 1'b1};
    endfunction : inc

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ack_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= req && !ack_q;
        end
    end

    // ==================================================================
    // configuration and management registers
    logic [31:0] cfg_q;
    logic [30:0] mgmt_q;
    logic mgmt_wr_q;
    logic mgmt_go_q;
    logic tx_eof_bit_q;
    assign mac_cfg_o = cfg_q;
    assign mgmt_cmd_o = mgmt_q;
    assign mgmt_write_o = mgmt_wr_q;
    assign mgmt_start_o = mgmt_go_q;

    // config steers the mac, management write launches a phy access unless mgmt_busy_i is high
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cfg_q <= pfh_pkg::PFH_CFG_RST;
            mgmt_q <= '0;
            mgmt_wr_q <= 1'b0;
            mgmt_go_q <= 1'b0;
        end else if (ce_i) begin
            mgmt_go_q <= 1'b0;
            if (wr_acc && hit(wb_adr_i, pfh_pkg::PFH_CFG_OFF)) begin
                cfg_q <= wb_dat_i; // R1
            end
            if (wr_acc && hit(wb_adr_i, pfh_pkg::PFH_MGMT_OFF) && !mgmt_busy_i) begin
                mgmt_q <= wb_dat_i[30:0]; // R1
                mgmt_wr_q <= wb_dat_i[pfh_pkg::PFH_MGMT_WRITE];
                mgmt_go_q <= 1'b1;
            end
        end
    end

    // end-of-frame marker that goes with the next transmit byte
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tx_eof_bit_q <= 1'b0;
        end else if (ce_i && wr_acc && hit(wb_adr_i, pfh_pkg::PFH_CTRL_OFF)) begin
            tx_eof_bit_q <= wb_dat_i[pfh_pkg::PFH_CTRL_EOF]; // R7 R8
        end
    end

    // ==================================================================
    // receive queue
    logic [8:0] rx_mem [DEPTH];
    logic [AW:0] rx_wp_q, rx_rp_q;
    logic rx_avail_q, rx_empty, rx_full, rx_push, rx_pop, rx_clr;
    assign rx_empty = rx_wp_q == rx_rp_q;
    assign rx_full = (rx_wp_q[AW] != rx_rp_q[AW]) && (rx_wp_q[AW-1:0] == rx_rp_q[AW-1:0]);
    // buffer belongs to the host while a frame is waiting
    assign rx_ready_o = !rx_avail_q && !rx_full;
    assign rx_push = ce_i && rx_wr_i && rx_ready_o;
    assign rx_pop = rd_acc && hit(wb_adr_i, pfh_pkg::PFH_RXD_OFF) && !rx_empty;
    assign rx_clr = wr_acc && hit(wb_adr_i, pfh_pkg::PFH_PKT_OFF)
        && wb_dat_i[pfh_pkg::PFH_PKT_RX_CLR];

    always_ff @(posedge clk_i) begin
        if (rx_push) begin
            rx_mem[rx_wp_q[AW-1:0]] <= {rx_eof_i, rx_data_i};
        end
    end

    // pointers: clearing the packet flag drops leftovers and frees the buffer
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rx_wp_q <= '0;
            rx_rp_q <= '0;
        end else if (ce_i) begin
            if (rx_clr) begin
                rx_wp_q <= '0; // R5
                rx_rp_q <= '0;
            end else begin
                if (rx_push) begin
                    rx_wp_q <= inc(rx_wp_q);
                end
                if (rx_pop) begin
                    rx_rp_q <= inc(rx_rp_q); // R2
                end
            end
        end
    end

    // frame ready on its last byte, or on the byte that fills the buffer
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rx_avail_q <= 1'b0;
        end else if (ce_i) begin
            if (rx_push && (rx_eof_i || inc(rx_wp_q) == {~rx_rp_q[AW], rx_rp_q[AW-1:0]})) begin
                rx_avail_q <= 1'b1;
            end else if (rx_clr) begin
                rx_avail_q <= 1'b0; // R5
            end
        end
    end

    // ==================================================================
    // transmit queue
    logic [8:0] tx_mem [DEPTH];
    logic [AW:0] tx_wp_q, tx_rp_q;
    logic tx_empty, tx_full, tx_push, tx_ovf, tx_pop, tx_go, tx_ready_q, tx_done_q;
    assign tx_empty = tx_wp_q == tx_rp_q;
    assign tx_full = (tx_wp_q[AW] != tx_rp_q[AW]) && (tx_wp_q[AW-1:0] == tx_rp_q[AW-1:0]);
    assign tx_push = wr_acc && hit(wb_adr_i, pfh_pkg::PFH_TXD_OFF) && !tx_full; // R11
    assign tx_ovf = wr_acc && hit(wb_adr_i, pfh_pkg::PFH_TXD_OFF) && tx_full;
    assign tx_pop = ce_i && tx_rd_i && tx_avail_o;
    assign tx_go = wr_acc && hit(wb_adr_i, pfh_pkg::PFH_PKT_OFF)
        && wb_dat_i[pfh_pkg::PFH_PKT_TX_GO];
    assign tx_frame_o = tx_ready_q;
    assign tx_avail_o = tx_ready_q && !tx_empty; // R10

    // byte and marker enter the queue on the bus write itself
    always_ff @(posedge clk_i) begin
        if (tx_push) begin
            tx_mem[tx_wp_q[AW-1:0]] <= {tx_eof_bit_q, wb_dat_i[7:0]}; // R9
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tx_wp_q <= '0;
            tx_rp_q <= '0;
        end else if (ce_i) begin
            if (tx_push) begin
                tx_wp_q <= inc(tx_wp_q); // R9
            end
            if (tx_pop) begin
                tx_rp_q <= inc(tx_rp_q);
            end
        end
    end

    // registered head of the queue towards the mac
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tx_data_o <= '0;
            tx_eof_o <= 1'b0;
        end else if (ce_i) begin
            {tx_eof_o, tx_data_o} <= tx_empty ? 9'h000 : tx_mem[tx_rp_q[AW-1:0]];
        end
    end

    // frame handed over by the host, finished when the mac reports done
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            tx_ready_q <= 1'b0;
            tx_done_q <= pfh_pkg::PFH_TX_DONE_RST;
        end else if (ce_i) begin
            if (tx_go) begin
                tx_ready_q <= 1'b1; // R10
                tx_done_q <= 1'b0;
            end else if (tx_done_i && tx_ready_q) begin
                tx_ready_q <= 1'b0;
                tx_done_q <= 1'b1; // R6
            end
        end
    end

    // ==================================================================
    // interrupts: sticky status, set wins over clear
    logic [pfh_pkg::PFH_IRQ_W-1:0] irq_st_q;
    logic [pfh_pkg::PFH_IRQ_W-1:0] irq_en_q;
    logic [pfh_pkg::PFH_IRQ_W-1:0] irq_set;
    logic [pfh_pkg::PFH_IRQ_W-1:0] irq_clr;
    assign irq_set = {ce_i && rx_wr_i && !rx_ready_o, tx_ovf,
        ce_i && tx_done_i && tx_ready_q, rx_push && !rx_avail_q && rx_eof_i};
    assign irq_clr = (wr_acc && hit(wb_adr_i, pfh_pkg::PFH_IRQ_CLR_OFF))
        ? wb_dat_i[pfh_pkg::PFH_IRQ_W-1:0] : '0;
    assign irq_o = |(irq_st_q & irq_en_q);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_st_q <= '0;
            irq_en_q <= pfh_pkg::PFH_IRQ_EN_RST;
        end else if (ce_i) begin
            irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
            if (wr_acc && hit(wb_adr_i, pfh_pkg::PFH_IRQ_EN_OFF)) begin
                irq_en_q <= wb_dat_i[pfh_pkg::PFH_IRQ_W-1:0];
            end
        end
    end

    // ==================================================================
    // read data, registered with the ack
    logic [31:0] stat;
    logic [31:0] rd_d;
    assign stat = {25'h0, mgmt_busy_i, tx_ready_q, tx_done_q, tx_full, tx_empty,
        rx_empty, rx_avail_q}; // R4 R6

    always_comb begin
        rd_d = 32'h0000_0000; // unmapped reads as zero
        if (hit(wb_adr_i, pfh_pkg::PFH_CFG_OFF)) begin
            rd_d = cfg_q;
        end else if (hit(wb_adr_i, pfh_pkg::PFH_MGMT_OFF)) begin
            rd_d = {mgmt_wr_q, mgmt_q};
        end else if (hit(wb_adr_i, pfh_pkg::PFH_MGMT_RD_OFF)) begin
            rd_d = {16'h0000, mgmt_rdata_i};
        end else if (hit(wb_adr_i, pfh_pkg::PFH_STAT_OFF)) begin
            rd_d = stat;
        end else if (hit(wb_adr_i, pfh_pkg::PFH_CTRL_OFF)) begin
            rd_d = {31'h0, tx_eof_bit_q};
        end else if (hit(wb_adr_i, pfh_pkg::PFH_RXD_OFF)) begin
            rd_d = rx_empty ? 32'h0000_0200 : {23'h0, rx_mem[rx_rp_q[AW-1:0]]}; // R2 R4
        end else if (hit(wb_adr_i, pfh_pkg::PFH_IRQ_STAT_OFF)) begin
            rd_d = {28'h0, irq_st_q};
        end else if (hit(wb_adr_i, pfh_pkg::PFH_IRQ_EN_OFF)) begin
            rd_d = {28'h0, irq_en_q};
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wb_dat_o <= '0;
        end else if (rd_acc) begin
            wb_dat_o <= rd_d;
        end
    end

    // ==================================================================
    // checks
    sequence host_go_s;
        tx_go;
    endsequence
    sequence mac_done_s;
        ce_i && tx_done_i && tx_ready_q;
    endsequence

    ack_pulse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ce_i && ack_q |=> !ack_q)
        else $error("ack held over two cycles");
    rx_order_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R2
        rx_pop && !rx_clr |=> rx_rp_q == inc($past(rx_rp_q)))
        else $error("receive read did not advance");
    rx_eof_flag_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R4
        rx_push && rx_eof_i |=> rx_avail_q && !rx_ready_o)
        else $error("end of frame did not raise packet ready");
    rx_free_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R5
        rx_clr && !rx_push |=> !rx_avail_q && rx_empty)
        else $error("buffer not freed after clear");
    tx_push_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R9
        tx_push |=> tx_mem[$past(tx_wp_q[AW-1:0])][8] == $past(tx_eof_bit_q))
        else $error("marker not stored with byte");
    tx_start_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R10
        host_go_s |=> tx_frame_o && !tx_done_q)
        else $error("frame not taken after packet ready");
    tx_finish_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R6
        mac_done_s and !tx_go |=> tx_done_q && !tx_frame_o)
        else $error("done flag not set after transmit");
    tx_full_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R11
        tx_ovf |=> tx_wp_q == $past(tx_wp_q) && irq_st_q[pfh_pkg::PFH_IRQ_TX_OVF])
        else $error("write into full queue was taken");
    cfg_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R1
        wr_acc && hit(wb_adr_i, pfh_pkg::PFH_CFG_OFF) |=> mac_cfg_o == $past(wb_dat_i))
        else $error("configuration write lost");
endmodule : pfh_host_port

// ### core/pfh_pkg.sv
// register map, field layout and reset values of the packet fifo host port
package pfh_pkg;
    // ==================================================================
    // register byte offsets (word aligned)
    localparam logic [7:0] PFH_CFG_OFF = 8'h00;
    localparam logic [7:0] PFH_MGMT_OFF = 8'h04;
    localparam logic [7:0] PFH_MGMT_RD_OFF = 8'h08;
    localparam logic [7:0] PFH_STAT_OFF = 8'h0c;
    localparam logic [7:0] PFH_CTRL_OFF = 8'h10;
    localparam logic [7:0] PFH_PKT_OFF = 8'h14;
    localparam logic [7:0] PFH_RXD_OFF = 8'h18;
    localparam logic [7:0] PFH_TXD_OFF = 8'h1c;
    localparam logic [7:0] PFH_IRQ_STAT_OFF = 8'h20;
    localparam logic [7:0] PFH_IRQ_EN_OFF = 8'h24;
    localparam logic [7:0] PFH_IRQ_CLR_OFF = 8'h28;
    // ==================================================================
    // field positions
    localparam int PFH_ST_RX_AVAIL = 0;
    localparam int PFH_ST_RX_EMPTY = 1;
    localparam int PFH_ST_TX_EMPTY = 2;
    localparam int PFH_ST_TX_FULL = 3;
    localparam int PFH_ST_TX_DONE = 4;
    localparam int PFH_ST_TX_READY = 5;
    localparam int PFH_ST_MGMT_BUSY = 6;
    localparam int PFH_PKT_RX_CLR = 0;
    localparam int PFH_PKT_TX_GO = 1;
    localparam int PFH_CTRL_EOF = 0;
    localparam int PFH_RXD_EOF = 8;
    localparam int PFH_RXD_EMPTY = 9;
    localparam int PFH_MGMT_WRITE = 31;
    // interrupt bits
    localparam int PFH_IRQ_RX_PKT = 0;
    localparam int PFH_IRQ_TX_DONE = 1;
    localparam int PFH_IRQ_TX_OVF = 2;
    localparam int PFH_IRQ_RX_DROP = 3;
    localparam int PFH_IRQ_W = 4;
    // ==================================================================
    // reset values
    localparam logic [31:0] PFH_CFG_RST = 32'h0000_0000;
    localparam logic [PFH_IRQ_W-1:0] PFH_IRQ_EN_RST = 4'h0;
    localparam logic PFH_TX_DONE_RST = 1'b1;
    localparam logic PFH_ACK_CYCLES = 1'b1;
endpackage : pfh_pkg

// ### dv/tb_pfh_host_port.sv
// self-checking bench for the packet fifo host port
`timescale 1ns/1ps
module tb_pfh_host_port;
    // ==================================================================
    // small queue keeps the fill and overflow cases short
    localparam int DEPTH = 16;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [15:0] mgmt_rdata_i = 16'h0;
    logic mgmt_busy_i = 1'b0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [3:0] sel_now = 4'hf;
    logic rx_wr_i = 1'b0;
    logic [7:0] rx_data_i = 8'h00;
    logic rx_eof_i = 1'b0;
    logic tx_rd_i = 1'b0;
    logic tx_done_i = 1'b0;
    logic [31:0] wb_dat_o, mac_cfg_o;
    logic [30:0] mgmt_cmd_o;
    logic [7:0] tx_data_o;
    logic wb_ack_o, irq_o, mgmt_start_o, mgmt_write_o, rx_ready_o, tx_frame_o, tx_avail_o;
    logic tx_eof_o;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    int n_start = 0;

    pfh_host_port #(.DEPTH(DEPTH)) DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .irq_o(irq_o), .mac_cfg_o(mac_cfg_o), .mgmt_start_o(mgmt_start_o),
        .mgmt_write_o(mgmt_write_o), .mgmt_cmd_o(mgmt_cmd_o), .mgmt_busy_i(mgmt_busy_i),
        .mgmt_rdata_i(mgmt_rdata_i), .rx_wr_i(rx_wr_i), .rx_data_i(rx_data_i),
        .rx_eof_i(rx_eof_i), .rx_ready_o(rx_ready_o), .tx_frame_o(tx_frame_o),
        .tx_avail_o(tx_avail_o), .tx_rd_i(tx_rd_i), .tx_data_o(tx_data_o),
        .tx_eof_o(tx_eof_o), .tx_done_i(tx_done_i));

    // ==================================================================
    // 125 mhz clock
    initial begin
        forever #4 clk_i = ~clk_i;
    end

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_mismatch++;
            test_done();
        end
    end

    // counts management launches, so a missing or extra pulse shows up
    always @(posedge clk_i) begin
        if (mgmt_start_o) begin
            n_start <= n_start + 1;
        end
    end

    // ==================================================================
    // verdict and comparisons
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    // expected status word, built from the flags at their field positions
    function automatic logic [31:0] exp_stat(input logic rx_pkt, input logic rx_mt,
            input logic tx_mt, input logic tx_fl, input logic done, input logic pend);
        logic [31:0] s;
        s = 32'h0000_0000;
        s[pfh_pkg::PFH_ST_RX_AVAIL] = rx_pkt;
        s[pfh_pkg::PFH_ST_RX_EMPTY] = rx_mt;
        s[pfh_pkg::PFH_ST_TX_EMPTY] = tx_mt;
        s[pfh_pkg::PFH_ST_TX_FULL] = tx_fl;
        s[pfh_pkg::PFH_ST_TX_DONE] = done;
        s[pfh_pkg::PFH_ST_TX_READY] = pend;
        return s;
    endfunction : exp_stat

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // classic cycle; ack sampled on the rising edge, data taken and request dropped there
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= sel_now;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rdchk

    // one receive byte per cycle from the mac side
    task automatic rx_byte(input logic [7:0] b, input logic eof);
        @(posedge clk_i);
        rx_wr_i <= 1'b1;
        rx_data_i <= b;
        rx_eof_i <= eof;
    endtask : rx_byte

    // ==================================================================
    // main sequence
    initial begin
        int len;
        logic [31:0] q;
        logic [7:0] fr[$];
        void'($urandom(94));
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(negedge clk_i);
        chk(rx_ready_o, 32'h1);
        chk(tx_frame_o, 32'h0);
        rdchk(pfh_pkg::PFH_STAT_OFF, exp_stat(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0));
        rdchk(pfh_pkg::PFH_IRQ_EN_OFF, 32'h0);
        rdchk(8'h3c, 32'h0);
        $display("reset test done");
        q = $urandom;
        wr(pfh_pkg::PFH_CFG_OFF, q);
        rdchk(pfh_pkg::PFH_CFG_OFF, q);
        chk(mac_cfg_o, q);
        // a write with byte lane 0 off must leave the register alone
        sel_now = 4'h0;
        wr(pfh_pkg::PFH_CFG_OFF, ~q);
        sel_now = 4'hf;
        rdchk(pfh_pkg::PFH_CFG_OFF, q);
        q = $urandom | 32'h8000_0000;
        wr(pfh_pkg::PFH_MGMT_OFF, q);
        chk({mgmt_write_o, mgmt_cmd_o}, q);
        @(posedge clk_i);
        mgmt_busy_i <= 1'b1;
        chk(n_start, 32'h1);
        // a busy engine refuses a new command and launches nothing
        wr(pfh_pkg::PFH_MGMT_OFF, 32'h0);
        mgmt_busy_i <= 1'b0;
        @(posedge clk_i);
        chk({mgmt_write_o, mgmt_cmd_o}, q);
        chk(n_start, 32'h1);
        q = $urandom;
        mgmt_rdata_i <= q[15:0];
        rdchk(pfh_pkg::PFH_MGMT_RD_OFF, {16'h0, q[15:0]});
        $display("register test done");
        // two frames: the second proves the buffer was freed
        for (int f = 0; f < 2; f++) begin
            len = 1 + $urandom % 8;
            fr.delete();
            wr(pfh_pkg::PFH_IRQ_EN_OFF, 32'h0);
            for (int i = 0; i < len; i++) begin
                fr.push_back(8'($urandom));
                rx_byte(fr[i], i == len - 1);
            end
            rx_byte(8'h55, 1'b1);
            @(posedge clk_i);
            rx_wr_i <= 1'b0;
            @(negedge clk_i);
            chk(rx_ready_o, 32'h0);
            chk(irq_o, 32'h0);
            wr(pfh_pkg::PFH_IRQ_EN_OFF, 32'hf);
            @(negedge clk_i);
            chk(irq_o, 32'h1);
            rdchk(pfh_pkg::PFH_IRQ_STAT_OFF, 32'h9);
            wr(pfh_pkg::PFH_IRQ_CLR_OFF, 32'hf);
            @(negedge clk_i);
            chk(irq_o, 32'h0);
            rdchk(pfh_pkg::PFH_STAT_OFF, exp_stat(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0));
            for (int i = 0; i < len; i++) begin
                rdchk(pfh_pkg::PFH_RXD_OFF, {23'h0, i == len - 1, fr[i]});
            end
            rdchk(pfh_pkg::PFH_STAT_OFF, exp_stat(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0));
            wr(pfh_pkg::PFH_PKT_OFF, 32'h1);
            @(negedge clk_i);
            chk(rx_ready_o, 32'h1);
        end
        $display("receive test done");
        // fill the queue, one write too many, then hand over and drain
        rdchk(pfh_pkg::PFH_STAT_OFF, exp_stat(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0));
        wr(pfh_pkg::PFH_CTRL_OFF, 32'h0);
        fr.delete();
        for (int i = 0; i <= DEPTH; i++) begin
            fr.push_back(8'($urandom));
            if (i == DEPTH - 1) begin
                wr(pfh_pkg::PFH_CTRL_OFF, 32'h1);
            end
            wr(pfh_pkg::PFH_TXD_OFF, {24'h0, fr[i]});
        end
        rdchk(pfh_pkg::PFH_IRQ_STAT_OFF, 32'h4);
        rdchk(pfh_pkg::PFH_STAT_OFF, exp_stat(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0));
        chk(tx_avail_o, 32'h0);
        wr(pfh_pkg::PFH_PKT_OFF, 32'h2);
        @(negedge clk_i);
        chk(tx_frame_o, 32'h1);
        rdchk(pfh_pkg::PFH_STAT_OFF, exp_stat(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1));
        for (int i = 0; i < DEPTH; i++) begin
            @(negedge clk_i);
            chk(tx_avail_o, 32'h1);
            chk({tx_eof_o, tx_data_o}, {i == DEPTH - 1, fr[i]});
            @(posedge clk_i);
            tx_rd_i <= 1'b1;
            @(posedge clk_i);
            tx_rd_i <= 1'b0;
            @(posedge clk_i);
        end
        @(negedge clk_i);
        chk(tx_avail_o, 32'h0);
        @(posedge clk_i);
        tx_done_i <= 1'b1;
        @(posedge clk_i);
        tx_done_i <= 1'b0;
        @(negedge clk_i);
        chk(tx_frame_o, 32'h0);
        rdchk(pfh_pkg::PFH_STAT_OFF, exp_stat(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0));
        rdchk(pfh_pkg::PFH_IRQ_STAT_OFF, 32'h6);
        $display("transmit test done");
        test_done();
    end
endmodule : tb_pfh_host_port
